// [core/iosc_ctrl.sv]
// Internal oscillator control: one control/status register, suspend and wake, ready
// flag, system clock divider and external oscillator pin claims.
// Assumes clk is the internal oscillator itself and a simple single-cycle register port.
//
// Function
// - Enable field at bits 7:6 stops the oscillator at 00 and runs it at 11 unless suspended; 01 and 10 are reserved.
// - Writing one to bit 5 puts the oscillator into suspend and halts its output.
// - A wake-up event ends suspend by hardware with no software action.
// - Read-only bit 4 reads 1 only while the oscillator runs at its programmed frequency.
// - Bit 3 is reserved, reads 0, and software writes 0 to it.
// - Bits 2:0 pick the system clock divisor, 128 at code 000 halving per code to 1 at code 111.
// - With the external drive in crystal mode, P0.2 becomes crystal input and P0.3 crystal output.
// - With the external drive in capacitor, RC or CMOS mode, only P0.3 is taken as clock pin.
//
// Design decision made here: the plain strobed port.
`include "iosc_regs.svh"

module iosc_ctrl #(
  parameter int SETTLE_CYCLES = (`IOSC_SETTLE_NS + `IOSC_CLK_PERIOD_NS - 1) / `IOSC_CLK_PERIOD_NS
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       wake_event,
  input  wire logic       ext_osc_enable,
  input  wire logic       ext_osc_crystal_mode,
  output logic            sys_clk_tick,
  output logic            osc_running,
  output logic            freq_ready_flag,
  output logic            crystal_in_pin_sel,
  output logic            crystal_out_pin_sel
);

  iosc_pkg::iosc_ctrl_s state_ff;
  iosc_pkg::iosc_ctrl_s nxt_state;
  iosc_div_if           dif ();

  logic hit;
  logic run;
  logic settled;
  logic run_after;

  function automatic logic iosc_runs(input logic [1:0] en, input logic susp);
    iosc_runs = (en == `IOSC_EN_ON) && !susp;
  endfunction

  assign hit     = reg_addr == `IOSC_REG_ADDR;
  // Reserved enable codes are held as written but treated as disabled
  assign run     = iosc_runs(state_ff.osc_enable_field, state_ff.suspend);
  assign settled = state_ff.settle_cnt >= 16'(SETTLE_CYCLES - 1);

  assign dif.run     = run;
  assign dif.div_sel = state_ff.clock_divide_select;

  iosc_clkdiv u_clkdiv (
    .clk   (clk),
    .rst_n (rst_n),
    .dif   (dif)
  );

  always_comb
  begin
    nxt_state = state_ff;
    nxt_state.rdata = `IOSC_RDATA_IDLE;
    // Wake first, so a suspend written in the same cycle still takes hold
    if (state_ff.suspend && wake_event)
    begin
      nxt_state.suspend = 1'b0;
    end
    if (reg_wr && hit)
    begin
      nxt_state.osc_enable_field    = reg_wdata[`IOSC_EN_HI:`IOSC_EN_LO];
      nxt_state.suspend             = reg_wdata[`IOSC_SUSP_BIT];
      nxt_state.clock_divide_select = reg_wdata[`IOSC_DIV_HI:`IOSC_DIV_LO];
    end
    // Ready drops at the very edge that stops the oscillator, so no read sees a stale 1
    run_after = iosc_runs(nxt_state.osc_enable_field, nxt_state.suspend);
    if (reg_rd && hit)
    begin
      nxt_state.rdata[`IOSC_EN_HI:`IOSC_EN_LO]   = state_ff.osc_enable_field;
      nxt_state.rdata[`IOSC_SUSP_BIT]            = state_ff.suspend;
      nxt_state.rdata[`IOSC_RDY_BIT]             = state_ff.osc_state == iosc_pkg::IOSC_READY;
      nxt_state.rdata[`IOSC_RSV_BIT]             = `IOSC_RSV_VALUE;
      nxt_state.rdata[`IOSC_DIV_HI:`IOSC_DIV_LO] = state_ff.clock_divide_select;
    end
    case (state_ff.osc_state)
      iosc_pkg::IOSC_OFF:
      begin
        nxt_state.settle_cnt = `IOSC_SETTLE_RESET;
        if (run)
        begin
          nxt_state.osc_state = iosc_pkg::IOSC_SETTLE;
        end
      end
      iosc_pkg::IOSC_SETTLE:
      begin
        if (!run || !run_after)
        begin
          nxt_state.osc_state = iosc_pkg::IOSC_OFF;
        end
        else if (settled)
        begin
          nxt_state.osc_state = iosc_pkg::IOSC_READY;
        end
        else
        begin
          nxt_state.settle_cnt = state_ff.settle_cnt + `IOSC_SETTLE_STEP;
        end
      end
      iosc_pkg::IOSC_READY:
      begin
        if (!run || !run_after)
        begin
          nxt_state.osc_state = iosc_pkg::IOSC_OFF;
        end
      end
      default:
      begin
        nxt_state.osc_state = iosc_pkg::IOSC_OFF;
      end
    endcase
    // Pin claims follow the external drive mode one cycle late
    nxt_state.crystal_in_pin_sel  = ext_osc_enable && ext_osc_crystal_mode;
    nxt_state.crystal_out_pin_sel = ext_osc_enable;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff.osc_enable_field    <= `IOSC_EN_RESET;
      state_ff.suspend             <= `IOSC_SUSP_RESET;
      state_ff.clock_divide_select <= `IOSC_DIV_RESET;
      state_ff.osc_state           <= iosc_pkg::IOSC_READY;
      state_ff.settle_cnt          <= `IOSC_SETTLE_RESET;
      state_ff.rdata               <= `IOSC_RDATA_IDLE;
      state_ff.crystal_in_pin_sel  <= 1'b0;
      state_ff.crystal_out_pin_sel <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign reg_rdata           = state_ff.rdata;
  assign sys_clk_tick        = dif.tick;
  assign osc_running         = run;
  assign freq_ready_flag     = state_ff.osc_state == iosc_pkg::IOSC_READY;
  assign crystal_in_pin_sel  = state_ff.crystal_in_pin_sel;
  assign crystal_out_pin_sel = state_ff.crystal_out_pin_sel;

  // Helper for the checks below: consecutive cycles of a running oscillator
  logic [15:0] run_cnt_ff;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run_cnt_ff <= `IOSC_SETTLE_RESET;
    end
    else if (!run)
    begin
      run_cnt_ff <= `IOSC_SETTLE_RESET;
    end
    else if (run_cnt_ff != 16'hffff)
    begin
      run_cnt_ff <= run_cnt_ff + `IOSC_SETTLE_STEP;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_reg_read;
    reg_rd && hit;
  endsequence

  sequence s_suspend_write;
    reg_wr && hit && reg_wdata[`IOSC_SUSP_BIT] && reg_wdata[`IOSC_EN_HI:`IOSC_EN_LO] == `IOSC_EN_ON;
  endsequence

  a_disable_stops: assert property (state_ff.osc_enable_field != `IOSC_EN_ON |-> !run && !sys_clk_tick)
    else $error("oscillator runs with enable field not on");
  a_suspend_halts: assert property (s_suspend_write |=> state_ff.suspend && !sys_clk_tick)
    else $error("suspend write did not halt the oscillator");
  a_wake_resumes: assert property (state_ff.suspend && wake_event && !(reg_wr && hit)
                                   |=> !state_ff.suspend)
    else $error("wake event did not end suspend");
  a_ready_read: assert property (s_reg_read |=> reg_rdata[`IOSC_RDY_BIT] == $past(freq_ready_flag))
    else $error("ready bit read back wrong");
  a_reserved_zero: assert property (s_reg_read |=> !reg_rdata[`IOSC_RSV_BIT])
    else $error("reserved bit read as one");
  a_divsel_read: assert property (s_reg_read |=> reg_rdata[`IOSC_DIV_HI:`IOSC_DIV_LO]
                                                 == $past(state_ff.clock_divide_select))
    else $error("divider code read back wrong");
  a_ready_off: assert property (!run |=> !freq_ready_flag)
    else $error("ready flag set while stopped");
  a_ready_gated: assert property (!run |-> !freq_ready_flag)
    else $error("ready flag set in the same cycle the oscillator stopped");
  a_ready_settle: assert property ($rose(freq_ready_flag) |-> run_cnt_ff >= 16'(SETTLE_CYCLES))
    else $error("ready flag rose before settling");
  a_crystal_pins: assert property (ext_osc_enable && ext_osc_crystal_mode
                                   |=> crystal_in_pin_sel && crystal_out_pin_sel)
    else $error("crystal mode pins not claimed");
  a_clock_pin: assert property (ext_osc_enable && !ext_osc_crystal_mode
                                |=> !crystal_in_pin_sel && crystal_out_pin_sel)
    else $error("clock mode pins claimed wrong");

endmodule

// [core/iosc_regs.svh]
// Register map, field positions, reset values and timing figures of the oscillator control.
// Assumes inclusion by bare name from every file that needs a number.
`ifndef IOSC_REGS_SVH
`define IOSC_REGS_SVH

`define IOSC_REG_ADDR       8'ha1
`define IOSC_EN_HI          7
`define IOSC_EN_LO          6
`define IOSC_SUSP_BIT       5
`define IOSC_RDY_BIT        4
`define IOSC_RSV_BIT        3
`define IOSC_DIV_HI         2
`define IOSC_DIV_LO         0
`define IOSC_EN_ON          2'h3
`define IOSC_EN_RESET       2'h3
`define IOSC_SUSP_RESET     1'h0
`define IOSC_DIV_RESET      3'h0
`define IOSC_RSV_VALUE      1'h0
`define IOSC_RDATA_IDLE     8'h00
`define IOSC_DIV_MAX_LIMIT  7'h7f
`define IOSC_CNT_ZERO       7'h00
`define IOSC_SETTLE_RESET   16'h0000
`define IOSC_SETTLE_STEP    16'h0001
`define IOSC_SETTLE_NS      1000
`define IOSC_CLK_PERIOD_NS  4

`endif

// [core/iosc_pkg.sv]
// Types shared by the oscillator control and its divider.
// Assumes the register header for all numeric constants.
package iosc_pkg;

  typedef enum logic [1:0] {
    IOSC_OFF    = 2'b00,
    IOSC_SETTLE = 2'b01,
    IOSC_READY  = 2'b10
  } iosc_osc_e;

  typedef struct packed {
    logic [1:0]  osc_enable_field;
    logic        suspend;
    logic [2:0]  clock_divide_select;
    iosc_osc_e   osc_state;
    logic [15:0] settle_cnt;
    logic [7:0]  rdata;
    logic        crystal_in_pin_sel;
    logic        crystal_out_pin_sel;
  } iosc_ctrl_s;

  typedef struct packed {
    logic [6:0] cnt;
    logic [2:0] cur_sel;
  } iosc_div_s;

endpackage

// [core/iosc_div_if.sv]
// Link between the oscillator control and the system clock divider.
// Assumes both ends run on the same clock.
interface iosc_div_if;
  logic       run;
  logic [2:0] div_sel;
  logic       tick;

  modport ctrl (
    output run,
    output div_sel,
    input  tick
  );

  modport div (
    input  run,
    input  div_sel,
    output tick
  );
endinterface

// [core/iosc_clkdiv.sv]
// System clock divider: one tick every 2^(7-sel) oscillator cycles.
// Assumes run and div_sel come from the oscillator control in the same clock domain.
`include "iosc_regs.svh"

module iosc_clkdiv (
  input  wire logic clk,
  input  wire logic rst_n,
  iosc_div_if.div   dif
);

  iosc_pkg::iosc_div_s state_ff;
  iosc_pkg::iosc_div_s nxt_state;

  function automatic logic [6:0] iosc_div_limit(input logic [2:0] sel);
    iosc_div_limit = `IOSC_DIV_MAX_LIMIT >> sel;
  endfunction

  // Divider code is only taken over at a period boundary or while stopped, so no short pulse appears
  assign dif.tick = dif.run && (state_ff.cnt == iosc_div_limit(state_ff.cur_sel));

  always_comb
  begin
    nxt_state = state_ff;
    if (!dif.run)
    begin
      nxt_state.cnt     = `IOSC_CNT_ZERO;
      nxt_state.cur_sel = dif.div_sel;
    end
    else if (dif.tick)
    begin
      nxt_state.cnt     = `IOSC_CNT_ZERO;
      nxt_state.cur_sel = dif.div_sel;
    end
    else
    begin
      nxt_state.cnt = state_ff.cnt + 7'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff.cnt     <= `IOSC_CNT_ZERO;
      state_ff.cur_sel <= `IOSC_DIV_RESET;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_tick_at_limit: assert property (dif.tick |-> state_ff.cnt == iosc_div_limit(state_ff.cur_sel))
    else $error("tick outside the divider limit");
  a_div_sel_swap: assert property ($changed(state_ff.cur_sel) |-> $past(dif.tick) || !$past(dif.run))
    else $error("divider code changed mid period");
  a_tick_gated: assert property (!dif.run |-> !dif.tick)
    else $error("system clock tick while oscillator stopped");
  a_div_by_two: assert property (dif.tick && dif.run && state_ff.cur_sel == 3'h6 && dif.div_sel == 3'h6
                                 |=> !dif.tick ##1 (dif.tick || !dif.run))
    else $error("divide by two spacing wrong");

endmodule

// [sim/iosc_xosc_model.sv]
// Behavioural external oscillator circuit beside the oscillator control.
// Assumes the bench asks for a drive state; software settings are folded into it.
module iosc_xosc_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic want_enable,
  input  wire logic want_crystal,
  output logic      ext_osc_enable,
  output logic      ext_osc_crystal_mode
);
  timeunit 1ns;
  timeprecision 1ps;

  // Type is fixed while the drive is off, so the enable never sees a half-made choice
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ext_osc_enable       <= 1'b0;
      ext_osc_crystal_mode <= 1'b0;
    end
    else if (!ext_osc_enable)
    begin
      ext_osc_crystal_mode <= want_crystal;
      ext_osc_enable       <= want_enable && (ext_osc_crystal_mode == want_crystal);
    end
    else if (!want_enable || (want_crystal != ext_osc_crystal_mode))
    begin
      ext_osc_enable <= 1'b0;
    end
  end
  // Crossbar skip and analog or digital input mode are assumed set by software here
endmodule

// [sim/iosc_ctrl_bench.sv]
// Self-checking bench for the oscillator control: register port, suspend, divider, pins.
// Assumes the design's header and a short settle parameter.
`include "iosc_regs.svh"

module iosc_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int ST = 4;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic       wake_event = 1'b0;
  logic       want_enable = 1'b0;
  logic       want_crystal = 1'b0;
  logic       ext_osc_enable;
  logic       ext_osc_crystal_mode;
  logic       sys_clk_tick;
  logic       osc_running;
  logic       freq_ready_flag;
  logic       crystal_in_pin_sel;
  logic       crystal_out_pin_sel;
  int         num_errors = 0;
  int         checks = 0;
  int         n;
  int         m;

  always #2 clk = ~clk;

  iosc_ctrl #(.SETTLE_CYCLES(ST)) dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .wake_event(wake_event), .ext_osc_enable(ext_osc_enable), .ext_osc_crystal_mode(ext_osc_crystal_mode),
    .sys_clk_tick(sys_clk_tick), .osc_running(osc_running), .freq_ready_flag(freq_ready_flag),
    .crystal_in_pin_sel(crystal_in_pin_sel), .crystal_out_pin_sel(crystal_out_pin_sel));

  iosc_xosc_model xosc (.clk(clk), .rst_n(rst_n), .want_enable(want_enable), .want_crystal(want_crystal),
    .ext_osc_enable(ext_osc_enable), .ext_osc_crystal_mode(ext_osc_crystal_mode));

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are looked at there
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    check("rdata", reg_rdata, exp);
  endtask

  task automatic idle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  task automatic tick_gap(output int g);
    g = 0;
    do
    begin
      @(posedge clk);
      #1;
      g++;
    end
    while (sys_clk_tick !== 1'b1 && g < 300);
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd(`IOSC_REG_ADDR, 8'hd0);
    wr(8'ha0, 8'h05);
    rd(`IOSC_REG_ADDR, 8'hd0);
    rd(8'ha0, 8'h00);
    // Bit 3 is written as 0, as software must
    wr(`IOSC_REG_ADDR, 8'hf7);
    idle(2);
    check("running", {7'h00, osc_running}, 8'h00);
    check("tick", {7'h00, sys_clk_tick}, 8'h00);
    check("ready", {7'h00, freq_ready_flag}, 8'h00);
    rd(`IOSC_REG_ADDR, 8'he7);
    @(posedge clk);
    wake_event <= 1'b1;
    @(posedge clk);
    wake_event <= 1'b0;
    #1;
    check("running", {7'h00, osc_running}, 8'h01);
    check("ready", {7'h00, freq_ready_flag}, 8'h00);
    idle(ST + 2);
    check("ready", {7'h00, freq_ready_flag}, 8'h01);
    rd(`IOSC_REG_ADDR, 8'hd7);
    // Write then read with no gap: the disable must already show in the ready bit
    @(posedge clk);
    reg_addr  <= `IOSC_REG_ADDR;
    reg_wdata <= 8'h07;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b1;
    @(posedge clk);
    reg_rd    <= 1'b0;
    #1;
    check("rdata_b2b", reg_rdata, 8'h07);
    for (int e = 0; e < 3; e++)
    begin
      wr(`IOSC_REG_ADDR, {e[1:0], 6'h07});
      idle(2);
      check("running", {7'h00, osc_running}, 8'h00);
      rd(`IOSC_REG_ADDR, {e[1:0], 6'h07});
      wr(`IOSC_REG_ADDR, 8'hc7);
      idle(ST + 3);
      check("ready", {7'h00, freq_ready_flag}, 8'h01);
    end
    wr(`IOSC_REG_ADDR, 8'hc0);
    for (int c = 0; c < 8; c++)
    begin
      tick_gap(n);
      wr(`IOSC_REG_ADDR, 8'hc0 | c[7:0]);
      tick_gap(n);
      check("gap_floor", {7'h00, (n + 2) >= (1 << (7 - c))}, 8'h01);
      tick_gap(m);
      check("period", m[7:0], 8'(1 << (7 - c)));
    end
    for (int p = 0; p < 3; p++)
    begin
      @(posedge clk);
      want_enable  <= (p != 0);
      want_crystal <= (p == 2);
      idle(6);
      check("pin_in", {7'h00, crystal_in_pin_sel}, {7'h00, p == 2});
      check("pin_out", {7'h00, crystal_out_pin_sel}, {7'h00, p != 0});
    end
    conclude();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    conclude();
  end
endmodule
